// File: src/cfg_loader_pkg.sv
package cfg_loader_pkg;

  // ****************************************************************
  // Flash image layout
  // ****************************************************************
  localparam int          ADDR_W          = 23;
  localparam logic [22:0] USER_IMAGE_BASE = 23'h40_0000;
  localparam logic [22:0] SAFE_IMAGE_BASE = 23'h60_0000;
  localparam logic [22:0] IMAGE_REGION_SZ = 23'h20_0000;
  localparam int          IMAGE_BYTES     = 1572864;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ            = 125000000;
  localparam int BLINK_MS          = 125;
  localparam int BLINK_CYCLES      = CLK_HZ / 1000 * BLINK_MS;
  localparam int FLASH_READ_NS     = 90;
  localparam int FLASH_READ_CYCLES = (FLASH_READ_NS * 125 + 999) / 1000;
  localparam int DONE_WAIT_CYCLES  = 64;

  // ****************************************************************
  // APB register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_IRQ     = 8'h08;
  localparam logic [7:0] REG_MASK    = 8'h0C;
  localparam logic [7:0] REG_ADDR    = 8'h10;

  localparam int CTRL_LOAD_USER = 0;
  localparam int CTRL_LOAD_SAFE = 1;
  localparam int CTRL_AUTO_BOOT = 2;
  localparam logic [2:0] CTRL_RESET = 3'b100;

  localparam int IRQ_DONE_USER = 0;
  localparam int IRQ_DONE_SAFE = 1;
  localparam int IRQ_USER_FAIL = 2;
  localparam int IRQ_ERROR     = 3;
  localparam int IRQ_W         = 4;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_READ   = 3'b011,
    ST_CLKLO  = 3'b010,
    ST_CLKHI  = 3'b110,
    ST_WAIT   = 3'b111,
    ST_DONE   = 3'b101,
    ST_FAIL   = 3'b100
  } load_state_t;

endpackage

// File: src/board_config_loader.sv
// The APB register port and the address map are this design's own decisions.
module board_config_loader #(
  parameter int BLINK_CYC = cfg_loader_pkg::BLINK_CYCLES,
  parameter int REGION_BYTES = 2097152
) (
  input  wire  logic                              pclk,            // 125 MHz clock
  input  wire  logic                              presetn,         // Power-on reset, active low
  input  wire  logic                              clk_en,          // Freezes state when low
  input  wire  logic                              psel,            // APB select
  input  wire  logic                              penable,         // APB enable
  input  wire  logic                              pwrite,          // APB direction
  input  wire  logic [7:0]                        paddr,           // APB byte address
  input  wire  logic [31:0]                       pwdata,          // APB write data
  output logic       [31:0]                       prdata,          // APB read data
  output logic                                    pready,          // APB ready
  output logic                                    pslverr,         // APB error
  output logic                                    irq,             // Level interrupt
  input  wire  logic                              reset_and_load_button_n, // Button, low pressed
  input  wire  logic                              safe_image_button_n,     // Button, low pressed
  input  wire  logic                              reload_req_n,    // Reload request from FPGA
  output logic                                    eth_reset_n,     // Ethernet reset
  output logic                                    flash_reset_n,   // Flash reset
  output logic                                    proto1_reset_n,  // Header 1 reset
  output logic                                    proto2_reset_n,  // Header 2 reset
  output logic [cfg_loader_pkg::ADDR_W-1:0]       flash_addr,      // Flash byte address
  output logic                                    flash_oe_n,      // Flash output enable
  output logic                                    flash_ce_n,      // Flash chip enable
  input  wire  logic [7:0]                        flash_data,      // Flash read data
  output logic                                    fpga_config_n,   // Configuration start, low
  output logic                                    fpga_dclk,       // Configuration clock
  output logic [7:0]                              fpga_data,       // Configuration byte
  input  wire  logic                              fpga_status_n,   // Low on config error
  input  wire  logic                              fpga_conf_done,  // High when configured
  output logic                                    led_loading,     // Blinks while loading
  output logic                                    led_error,       // Nothing loaded
  output logic                                    led_user,        // User image
  output logic                                    led_safe         // Safe image
);
  import cfg_loader_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0]        s1;
    logic [2:0]        s2;
    logic [2:0]        prev;
    load_state_t       st;
    logic              safe;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] count;
    logic [7:0]        data;
    logic [7:0]        wait_cnt;
    logic [26:0]       blink_cnt;
    logic              blink;
    logic              done_user;
    logic              done_safe;
    logic              error;
    logic              user_lit;
    logic              safe_lit;
    logic              config_n;
    logic              dclk;
    logic              oe_n;
    logic [2:0]        ctrl;
    logic [IRQ_W-1:0]  irq_st;
    logic [IRQ_W-1:0]  mask;
    logic [31:0]       rdata;
    logic              pwr_start;
    logic [1:0]        f1;
    logic [1:0]        f2;
  } state_t;

  state_t r;
  state_t next_r;

  logic [2:0] trig;
  logic       st_err;
  logic       st_done;
  logic       wr_acc;
  logic       load_safe_req;
  logic       load_user_req;
  logic [IRQ_W-1:0] ev;

  // Last byte index of one image region
  localparam logic [ADDR_W-1:0] REGION_LAST = ADDR_W'(REGION_BYTES - 1);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_r  = r;
    ev      = '0;

    // ****************************************************************
    // Synchronisers and edge detect
    // ****************************************************************
    next_r.s1 = {safe_image_button_n, reload_req_n, reset_and_load_button_n};
    next_r.s2 = r.s1;
    next_r.f1 = {fpga_conf_done, fpga_status_n};
    next_r.f2 = r.f1;
    next_r.prev = r.s2;
    st_err  = ~r.f2[0];
    st_done = r.f2[1];
    // Falling edges: bit0 reset-and-load, bit1 reload request, bit2 safe
    trig    = r.prev & ~r.s2;
    wr_acc  = psel & penable & pwrite;
    load_safe_req = trig[2] || (wr_acc && paddr == REG_CTRL && pwdata[CTRL_LOAD_SAFE]);
    load_user_req = trig[0] || trig[1] || r.pwr_start
                    || (wr_acc && paddr == REG_CTRL && pwdata[CTRL_LOAD_USER]);
    next_r.pwr_start = 1'b0;

    // ****************************************************************
    // Load sequencer
    // ****************************************************************
    unique case (r.st)
      ST_IDLE: begin
        // Flash released, configuration port quiet
        next_r.config_n = 1'b1;
        next_r.dclk     = 1'b0;
        next_r.oe_n     = 1'b1;
      end
      ST_START: begin
        // Config start pulses low for one cycle
        next_r.config_n = 1'b0;
        next_r.count    = '0;
        next_r.addr     = r.safe ? SAFE_IMAGE_BASE : USER_IMAGE_BASE;
        next_r.wait_cnt = 8'(DONE_WAIT_CYCLES);
        next_r.st       = ST_READ;
        next_r.oe_n     = 1'b0;
      end
      ST_READ: begin
        next_r.config_n = 1'b1;
        next_r.dclk     = 1'b0;
        // Let the flash access time elapse
        if (r.wait_cnt > 8'(DONE_WAIT_CYCLES - FLASH_READ_CYCLES)) begin
          next_r.wait_cnt = r.wait_cnt - 8'd1;
        end else begin
          next_r.data     = flash_data;
          next_r.st       = ST_CLKLO;
        end
      end
      ST_CLKLO: begin
        // Byte stands a full cycle before the edge
        next_r.dclk = 1'b1;
        next_r.st   = ST_CLKHI;
      end
      ST_CLKHI: begin
        next_r.dclk     = 1'b0;
        next_r.wait_cnt = 8'(DONE_WAIT_CYCLES);
        // Done arrives through the synchroniser, one byte late
        if (st_done) begin
          next_r.st   = ST_DONE;
          next_r.oe_n = 1'b1;
        end else if (st_err || r.count == REGION_LAST) begin
          next_r.st = ST_FAIL;
        end else begin
          next_r.addr  = r.addr + ADDR_W'(1);
          next_r.count = r.count + ADDR_W'(1);
          next_r.st    = ST_READ;
        end
      end
      ST_DONE: begin
        next_r.oe_n = 1'b1;
        if (r.safe) begin
          next_r.done_safe = 1'b1;
          ev[IRQ_DONE_SAFE] = 1'b1;
        end else begin
          next_r.done_user = 1'b1;
          ev[IRQ_DONE_USER] = 1'b1;
        end
        next_r.st = ST_IDLE;
      end
      ST_FAIL: begin
        next_r.oe_n = 1'b1;
        // Only one fallback, then give up
        if (!r.safe) begin
          next_r.safe = 1'b1;
          ev[IRQ_USER_FAIL] = 1'b1;
          next_r.st = ST_START;
        end else begin
          next_r.error = 1'b1;
          ev[IRQ_ERROR] = 1'b1;
          next_r.st = ST_IDLE;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase

    // ****************************************************************
    // Start requests, safe button takes precedence
    // ****************************************************************
    if (load_safe_req) begin
      next_r.safe = 1'b1;
      next_r.st   = ST_START;
      next_r.done_user = 1'b0;
      next_r.done_safe = 1'b0;
      next_r.error     = 1'b0;
    end else if (load_user_req) begin
      next_r.safe = 1'b0;
      next_r.st   = ST_START;
      next_r.done_user = 1'b0;
      next_r.done_safe = 1'b0;
      next_r.error     = 1'b0;
    end

    // ****************************************************************
    // Power-on load never held off, since reset sets auto boot (CTRL_RESET)
    // ****************************************************************
    if (r.pwr_start && !r.ctrl[CTRL_AUTO_BOOT]) begin
      next_r.st = ST_IDLE;
    end

    // ****************************************************************
    // Loading indicator
    // ****************************************************************
    if (r.st != ST_IDLE) begin
      if (r.blink_cnt == 27'(BLINK_CYC - 1)) begin
        next_r.blink_cnt = '0;
        next_r.blink     = ~r.blink;
      end else begin
        next_r.blink_cnt = r.blink_cnt + 27'd1;
      end
    end else begin
      next_r.blink_cnt = '0;
      next_r.blink     = 1'b0;
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    if (wr_acc && paddr == REG_CTRL) begin
      next_r.ctrl = pwdata[2:0];
    end
    if (wr_acc && paddr == REG_MASK) begin
      next_r.mask = pwdata[IRQ_W-1:0];
    end

    // ****************************************************************
    // Interrupt status, set wins over clear
    // ****************************************************************
    if (wr_acc && paddr == REG_IRQ) begin
      next_r.irq_st = (r.irq_st & ~pwdata[IRQ_W-1:0]) | ev;
    end else begin
      next_r.irq_st = r.irq_st | ev;
    end

    // ****************************************************************
    // Read data, latched in the setup cycle
    // ****************************************************************
    next_r.rdata = '0;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        REG_CTRL:   next_r.rdata = {29'd0, r.ctrl};
        REG_STATUS: next_r.rdata = {23'd0, r.f2, r.st, r.safe,
                                    r.done_user, r.done_safe, r.error};
        REG_IRQ:    next_r.rdata = {28'd0, r.irq_st};
        REG_MASK:   next_r.rdata = {28'd0, r.mask};
        REG_ADDR:   next_r.rdata = {9'd0, r.addr};
        default:    next_r.rdata = '0;
      endcase
    end

    // ****************************************************************
    // Image indicators follow the next state
    // ****************************************************************
    next_r.user_lit = ~next_r.safe && (next_r.st != ST_IDLE || next_r.done_user);
    next_r.safe_lit = next_r.safe && (next_r.st != ST_IDLE || next_r.done_safe);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r           <= '0;
      // Pins idle high, so no false edge after reset
      r.s1        <= 3'b111;
      r.s2        <= 3'b111;
      r.prev      <= 3'b111;
      r.st        <= ST_IDLE;
      r.config_n  <= 1'b1;
      r.oe_n      <= 1'b1;
      r.ctrl      <= CTRL_RESET;
      r.f1        <= 2'b01;
      r.f2        <= 2'b01;
      r.pwr_start <= 1'b1;
    end else if (clk_en) begin
      // Low enable freezes every flop
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign eth_reset_n    = presetn;
  assign flash_reset_n  = presetn;
  assign proto1_reset_n = presetn;
  assign proto2_reset_n = presetn;

  // ****************************************************************
  // Flash and configuration port
  // ****************************************************************
  assign flash_addr     = r.addr;
  assign flash_oe_n     = r.oe_n;
  assign flash_ce_n     = r.oe_n;
  assign fpga_config_n  = r.config_n;
  assign fpga_dclk      = r.dclk;
  assign fpga_data      = r.data;

  // ****************************************************************
  // Indicators
  // ****************************************************************
  assign led_loading    = r.blink;
  assign led_error      = r.error;
  assign led_user       = r.user_lit;
  assign led_safe       = r.safe_lit;

  // ****************************************************************
  // Register bus and interrupt
  // ****************************************************************
  assign prdata         = r.rdata;
  assign pready         = 1'b1;
  assign pslverr        = 1'b0;
  assign irq            = |(r.irq_st & r.mask);

endmodule // board_config_loader

// File: testbench/flash_fpga_model.sv
module flash_fpga_model (
  input  wire logic                            pclk,
  input  wire logic [cfg_loader_pkg::ADDR_W-1:0] flash_addr,
  input  wire logic                            flash_oe_n,
  input  wire logic                            flash_ce_n,
  input  wire logic                            fpga_config_n,
  input  wire logic                            fpga_dclk,
  input  wire logic [7:0]                      fpga_data,
  input  wire logic [1:0]                      user_mode,
  input  wire logic                            safe_ok,
  output logic      [7:0]                      flash_data,
  output logic                                 fpga_status_n,
  output logic                                 fpga_conf_done,
  output int                                   bad_bytes
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_loader_pkg::*;
  localparam int IMG_N = 8;
  logic [7:0] last = 8'h00;
  int         nbytes = 0;
  logic       good;
  logic       bad;
  function automatic logic [7:0] img(input logic [22:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  // Released bus shows a changing pattern
  assign flash_data = (!flash_ce_n && !flash_oe_n) ? img(flash_addr) : ~last;
  assign good = flash_addr[21] ? safe_ok : (user_mode == 2'h2);
  assign bad  = flash_addr[21] ? !safe_ok : (user_mode == 2'h1);
  initial begin
    fpga_status_n = 1'b1;
    fpga_conf_done = 1'b0;
    bad_bytes = 0;
  end
  always @(posedge pclk) begin
    last <= flash_data;
    if (!fpga_config_n) begin
      nbytes <= 0;
      fpga_status_n <= 1'b1;
      fpga_conf_done <= 1'b0;
    end else if (fpga_dclk) begin
      nbytes <= nbytes + 1;
      if (fpga_data !== img(flash_addr)) bad_bytes <= bad_bytes + 1;
      if (nbytes == IMG_N - 1 && good) fpga_conf_done <= 1'b1;
      if (nbytes == IMG_N - 1 && bad) fpga_status_n <= 1'b0;
    end
  end
endmodule // flash_fpga_model

// File: testbench/board_config_loader_props.sv
module cfg_loader_props #(
  parameter int BLINK_CYC = 4
) (
  input wire logic                              pclk,
  input wire logic                              presetn,
  input wire logic                              reset_and_load_button_n,
  input wire logic                              safe_image_button_n,
  input wire logic                              reload_req_n,
  input wire logic                              eth_reset_n,
  input wire logic                              flash_reset_n,
  input wire logic                              proto1_reset_n,
  input wire logic                              proto2_reset_n,
  input wire logic [cfg_loader_pkg::ADDR_W-1:0] flash_addr,
  input wire logic                              fpga_config_n,
  input wire logic                              fpga_dclk,
  input wire logic                              fpga_conf_done,
  input wire logic                              led_loading,
  input wire logic                              led_error,
  input wire logic                              led_user,
  input wire logic                              led_safe
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_loader_pkg::*;
  localparam int BLINK_WIN = 2 * BLINK_CYC + 2;
  logic        have;
  logic [22:0] last_a;
  int          done_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Previous byte address and time since done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      have <= 1'b0;
      last_a <= 23'h0;
      done_cnt <= 0;
    end else begin
      if (!fpga_config_n) have <= 1'b0;
      else if (fpga_dclk) have <= 1'b1;
      if (fpga_dclk) last_a <= flash_addr;
      done_cnt <= fpga_conf_done ? done_cnt + 1 : 0;
    end
  end
  sequence s_start; $fell(fpga_config_n); endsequence
  sequence s_byte; fpga_dclk && have; endsequence
  property p_fanout; 1 |-> eth_reset_n && flash_reset_n && proto1_reset_n && proto2_reset_n; endproperty
  property p_start; s_start |=> fpga_config_n; endproperty
  property p_base; s_start |-> flash_addr == USER_IMAGE_BASE || flash_addr == SAFE_IMAGE_BASE; endproperty
  property p_dclk; fpga_dclk |=> !fpga_dclk; endproperty
  property p_seq; s_byte |-> flash_addr == last_a + 23'h1; endproperty
  property p_stop; done_cnt > 20 |-> !fpga_dclk; endproperty
  property p_blink; s_start |-> ##[1:BLINK_WIN] $changed(led_loading); endproperty
  property p_err_led; led_error |-> !led_user && !led_safe; endproperty
  property p_user_led; fpga_dclk && !flash_addr[21] |-> led_user; endproperty
  property p_safe_led; fpga_dclk && flash_addr[21] |-> led_safe; endproperty
  property p_trig;
    $fell(reload_req_n) || $fell(reset_and_load_button_n) |->
      ##[2:8] ($fell(fpga_config_n) && flash_addr == USER_IMAGE_BASE);
  endproperty
  property p_safe_btn;
    $fell(safe_image_button_n) |-> ##[2:8] ($fell(fpga_config_n) && flash_addr == SAFE_IMAGE_BASE);
  endproperty
  a_fanout: assert property (p_fanout) else $error("board resets low");
  a_start: assert property (p_start) else $error("config start not one cycle");
  a_base: assert property (p_base) else $error("bad image base");
  a_dclk: assert property (p_dclk) else $error("dclk not a pulse");
  a_seq: assert property (p_seq) else $error("address not sequential");
  a_stop: assert property (p_stop) else $error("fetch after done");
  a_blink: assert property (p_blink) else $error("loading led still");
  a_err_led: assert property (p_err_led) else $error("error led with image led");
  a_user_led: assert property (p_user_led) else $error("user led off");
  a_safe_led: assert property (p_safe_led) else $error("safe led off");
  a_trig: assert property (p_trig) else $error("no user load start");
  a_safe_btn: assert property (p_safe_btn) else $error("no safe load start");
endmodule // cfg_loader_props

bind board_config_loader cfg_loader_props #(.BLINK_CYC(BLINK_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .reset_and_load_button_n(reset_and_load_button_n),
  .safe_image_button_n(safe_image_button_n), .reload_req_n(reload_req_n), .eth_reset_n(eth_reset_n),
  .flash_reset_n(flash_reset_n), .proto1_reset_n(proto1_reset_n), .proto2_reset_n(proto2_reset_n),
  .flash_addr(flash_addr), .fpga_config_n(fpga_config_n), .fpga_dclk(fpga_dclk),
  .fpga_conf_done(fpga_conf_done), .led_loading(led_loading), .led_error(led_error),
  .led_user(led_user), .led_safe(led_safe));

// File: testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_loader_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        load_btn_n = 1'b1, safe_btn_n = 1'b1, reload_req_n = 1'b1, safe_ok = 1'b1;
  logic [1:0]  user_mode = 2'h2;
  logic [7:0]  paddr = 8'h00, fdata, fpga_data;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [22:0] flash_addr, bases[$];
  logic        pready, pslverr, irq, eth_n, fl_n, p1_n, p2_n, oe_n, ce_n, cfg_n, dclk, st_n, cdone;
  logic        led_ld, led_err, led_usr, led_sf, grab = 1'b0;
  int          err_count = 0, total_checks = 0, bad_bytes, idle;
  initial begin
    forever #4 pclk = ~pclk;
  end
  board_config_loader #(.BLINK_CYC(4), .REGION_BYTES(64)) dut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .reset_and_load_button_n(load_btn_n), .safe_image_button_n(safe_btn_n), .reload_req_n(reload_req_n),
    .eth_reset_n(eth_n), .flash_reset_n(fl_n), .proto1_reset_n(p1_n), .proto2_reset_n(p2_n),
    .flash_addr(flash_addr), .flash_oe_n(oe_n), .flash_ce_n(ce_n), .flash_data(fdata),
    .fpga_config_n(cfg_n), .fpga_dclk(dclk), .fpga_data(fpga_data), .fpga_status_n(st_n),
    .fpga_conf_done(cdone), .led_loading(led_ld), .led_error(led_err), .led_user(led_usr),
    .led_safe(led_sf));
  flash_fpga_model partner (
    .pclk(pclk), .flash_addr(flash_addr), .flash_oe_n(oe_n), .flash_ce_n(ce_n), .fpga_config_n(cfg_n),
    .fpga_dclk(dclk), .fpga_data(fpga_data), .user_mode(user_mode), .safe_ok(safe_ok),
    .flash_data(fdata), .fpga_status_n(st_n), .fpga_conf_done(cdone), .bad_bytes(bad_bytes));
  // First byte address of every load
  always @(posedge pclk) begin
    if (!cfg_n) grab <= 1'b1;
    else if (dclk && grab) begin
      bases.push_back(flash_addr);
      grab <= 1'b0;
    end
  end
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    idle = 0;
    while (idle < 300) begin
      @(posedge pclk);
      idle = dclk ? 0 : idle + 1;
    end
  endtask
  task automatic trig(input int k);
    @(posedge pclk);
    if (k == 0) reload_req_n <= 1'b0;
    else if (k == 1) safe_btn_n <= 1'b0;
    else load_btn_n <= 1'b0;
    repeat (4) @(posedge pclk);
    {reload_req_n, safe_btn_n, load_btn_n} <= 3'b111;
    settle();
  endtask
  task automatic result(input logic [2:0] leds, input logic [22:0] b0, input logic [22:0] b1, input int n);
    chk({29'h0, led_err, led_sf, led_usr}, {29'h0, leds});
    chk(bases.size(), n);
    chk({9'h0, bases[0]}, {9'h0, b0});
    if (n > 1) chk({9'h0, bases[n-1]}, {9'h0, b1});
    bases.delete();
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    chk({28'h0, eth_n, fl_n, p1_n, p2_n}, 32'h0);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({28'h0, eth_n, fl_n, p1_n, p2_n}, 32'hf);
    settle();
    result(3'b001, USER_IMAGE_BASE, USER_IMAGE_BASE, 1);
    // ******
    // Interrupt masked, raised, cleared
    // ******
    apb(1'b1, REG_MASK, 32'h0);
    apb(1'b0, REG_IRQ, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, REG_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, REG_IRQ, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, REG_IRQ, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    apb(1'b1, REG_CTRL, 32'h6);
    settle();
    result(3'b010, SAFE_IMAGE_BASE, SAFE_IMAGE_BASE, 1);
    trig(1);
    result(3'b010, SAFE_IMAGE_BASE, SAFE_IMAGE_BASE, 1);
    user_mode <= 2'h1;
    trig(0);
    result(3'b010, USER_IMAGE_BASE, SAFE_IMAGE_BASE, 2);
    user_mode <= 2'h0;
    trig(2);
    result(3'b010, USER_IMAGE_BASE, SAFE_IMAGE_BASE, 2);
    safe_ok <= 1'b0;
    trig(0);
    result(3'b100, USER_IMAGE_BASE, SAFE_IMAGE_BASE, 2);
    {user_mode, safe_ok} <= 3'b101;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({28'h0, eth_n, fl_n, p1_n, p2_n}, 32'h0);
    presetn <= 1'b1;
    settle();
    result(3'b001, USER_IMAGE_BASE, USER_IMAGE_BASE, 1);
    chk(bad_bytes, 0);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    complete_run();
  end
endmodule // testbench
